// [ssw_map.vh]
// timing constants for the supply supervisor and watchdog
// assumes a 50 mhz system clock; times in their printed units
`ifndef SSW_MAP_VH
`define SSW_MAP_VH
`define SSW_CLK_HZ 50000000
`define SSW_HOLD_MS 200
`define SSW_HOLD_CYC ((`SSW_CLK_HZ / 1000) * `SSW_HOLD_MS)
`define SSW_WD_DMS 16
`define SSW_WD_CYC ((`SSW_CLK_HZ / 10) * `SSW_WD_DMS)
`define SSW_KICK_MAX_MS 35
`define SSW_KICK_MAX_CYC ((`SSW_CLK_HZ / 1000) * `SSW_KICK_MAX_MS)
`define SSW_MR_FILT_NS 100
`define SSW_MR_FILT_CYC ((`SSW_MR_FILT_NS * 50 + 999) / 1000)
`define SSW_MR_DELAY_US 12
`define SSW_MR_DELAY_CYC ((`SSW_CLK_HZ / 1000000) * `SSW_MR_DELAY_US)
`define SSW_PIN_HIGH 1'b1
`endif

// [ssw_pin_sync.v]
// three-stage pin synchroniser with agreement of stages two and three
// assumes an asynchronous pin level on pin_in
module ssw_pin_sync #(
	parameter RESET_VAL = 1'b1
) (
	sys_clk,
	sys_rst,
	pin_in,
	level_out
);
	input wire sys_clk;
	input wire sys_rst;
	input wire pin_in;
	output reg level_out;

	reg s1_reg;
	reg s2_reg;
	reg s3_reg;

	always @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			s1_reg <= RESET_VAL;
			s2_reg <= RESET_VAL;
			s3_reg <= RESET_VAL;
			level_out <= RESET_VAL;
		end
		else
		begin
			s1_reg <= pin_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg)
				level_out <= s3_reg;
		end
	end
endmodule // ssw_pin_sync

// [ssw_supervisor.v]
// supply supervisor: reset hold, manual reset filter, watchdog, power fail
// assumes pins are asynchronous; comparators outside give logic levels
// assumes hold and watchdog periods are given in clock cycles
// assumes the manual pin pull-up shows as its enable held high
`include "ssw_map.vh"
module ssw_supervisor #(
	parameter HOLD_CYC = `SSW_HOLD_CYC,
	parameter WD_CYC = `SSW_WD_CYC,
	parameter MR_FILT_CYC = `SSW_MR_FILT_CYC
) (
	sys_clk,
	sys_rst,
	supply_low,
	manual_reset_n,
	manual_reset_n_oe_n,
	watchdog_kick,
	power_fail_sense,
	reset_n,
	watchdog_expired_n,
	power_fail_flag_n
);
	input wire sys_clk;
	input wire sys_rst;
	input wire supply_low;
	input wire manual_reset_n;
	input wire manual_reset_n_oe_n;
	input wire watchdog_kick;
	input wire power_fail_sense;
	output reg reset_n;
	output reg watchdog_expired_n;
	output reg power_fail_flag_n;

	wire supply_low_s;
	wire mr_s;
	wire kick_s;
	wire pf_s;
	wire mr_pin;
	reg kick_prev_reg;
	reg mr_filt_reg;
	reg [7:0] mr_cnt_reg;
	reg [31:0] hold_cnt_reg;
	reg [31:0] hold_cnt_next;
	reg [31:0] wd_cnt_reg;
	reg [31:0] wd_cnt_next;
	reg [1:0] rst_state_reg;
	reg [1:0] rst_state_next;
	reg [1:0] wd_state_reg;
	reg [1:0] wd_state_next;
	reg mr_filt_next;
	reg [7:0] mr_cnt_next;
	reg pf_flag_next;
	reg cause;
	reg kick_edge;

	// reset sequencer states
	localparam RST_ASSERT = 2'b00;
	localparam RST_HOLD = 2'b01;
	localparam RST_RUN = 2'b10;

	// watchdog states; output is low unless counting
	localparam WD_OFF = 2'b00;
	localparam WD_COUNT = 2'b01;
	localparam WD_EXPIRED = 2'b10;

	// true once a counter has reached its last cycle
	function ssw_reached;
		input [31:0] cnt;
		input [31:0] lim;
		begin
			ssw_reached = (cnt >= lim - 32'h00000001);
		end
	endfunction

	function [31:0] ssw_inc32;
		input [31:0] v;
		begin
			ssw_inc32 = v + 32'h00000001;
		end
	endfunction

	// floating pin (no driver enabled) reads as pulled high
	assign mr_pin = manual_reset_n_oe_n ? `SSW_PIN_HIGH : manual_reset_n;

	// every pin passes four flops before it is used
	ssw_pin_sync #(.RESET_VAL(1'b0)) u_vcc (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.pin_in(supply_low),
		.level_out(supply_low_s)
	);
	ssw_pin_sync #(.RESET_VAL(1'b1)) u_mr (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.pin_in(mr_pin),
		.level_out(mr_s)
	);
	ssw_pin_sync #(.RESET_VAL(1'b0)) u_kick (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.pin_in(watchdog_kick),
		.level_out(kick_s)
	);
	ssw_pin_sync #(.RESET_VAL(1'b1)) u_pf (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.pin_in(power_fail_sense),
		.level_out(pf_s)
	);

	// low must persist the glitch window before it counts
	always @*
	begin
		mr_filt_next = mr_filt_reg;
		mr_cnt_next = mr_cnt_reg;
		if (mr_s)
		begin
			mr_filt_next = 1'b1;
			mr_cnt_next = 8'h00;
		end
		else if (ssw_reached({24'h000000, mr_cnt_reg}, MR_FILT_CYC + 1))
			mr_filt_next = 1'b0;
		else
			mr_cnt_next = mr_cnt_reg + 8'h01;
	end

	always @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			mr_filt_reg <= 1'b1;
			mr_cnt_reg <= 8'h00;
		end
		else
		begin
			mr_filt_reg <= mr_filt_next;
			mr_cnt_reg <= mr_cnt_next;
		end
	end

	// reset causes; watchdog expiry is deliberately not one
	always @*
	begin
		cause = 1'b0;
		if (supply_low_s)
			cause = 1'b1;
		if (!mr_filt_reg)
			cause = 1'b1;
	end

	// either kick direction counts as activity
	always @*
	begin
		kick_edge = 1'b0;
		if (kick_s != kick_prev_reg)
			kick_edge = 1'b1;
	end

	// reset sequencer: any cause restarts the full hold
	always @*
	begin
		rst_state_next = rst_state_reg;
		hold_cnt_next = hold_cnt_reg;
		case (rst_state_reg)
			RST_ASSERT, RST_HOLD:
			begin
				if (cause)
				begin
					rst_state_next = RST_ASSERT;
					hold_cnt_next = 32'h00000000;
				end
				else if (ssw_reached(hold_cnt_reg, HOLD_CYC))
					rst_state_next = RST_RUN;
				else
				begin
					rst_state_next = RST_HOLD;
					hold_cnt_next = ssw_inc32(hold_cnt_reg);
				end
			end
			RST_RUN:
			begin
				if (cause)
				begin
					rst_state_next = RST_ASSERT;
					hold_cnt_next = 32'h00000000;
				end
			end
			default:
			begin
				rst_state_next = RST_ASSERT;
				hold_cnt_next = 32'h00000000;
			end
		endcase
	end

	always @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			rst_state_reg <= RST_ASSERT;
			hold_cnt_reg <= 32'h00000000;
			reset_n <= 1'b0;
		end
		else
		begin
			rst_state_reg <= rst_state_next;
			hold_cnt_reg <= hold_cnt_next;
			reset_n <= (rst_state_next == RST_RUN);
		end
	end

	// watchdog: kicks and active reset clear it
	always @*
	begin
		wd_state_next = wd_state_reg;
		wd_cnt_next = wd_cnt_reg;
		if (supply_low_s)
		begin
			wd_state_next = WD_OFF;
			wd_cnt_next = 32'h00000000;
		end
		else if (kick_edge || !reset_n)
		begin
			wd_state_next = WD_COUNT;
			wd_cnt_next = 32'h00000000;
		end
		else
		begin
			case (wd_state_reg)
				WD_COUNT:
				begin
					if (ssw_reached(wd_cnt_reg, WD_CYC))
						wd_state_next = WD_EXPIRED;
					else
						wd_cnt_next = ssw_inc32(wd_cnt_reg);
				end
				WD_EXPIRED:
					wd_state_next = WD_EXPIRED;
				WD_OFF:
				begin
					wd_state_next = WD_COUNT;
					wd_cnt_next = 32'h00000000;
				end
				default:
				begin
					wd_state_next = WD_OFF;
					wd_cnt_next = 32'h00000000;
				end
			endcase
		end
	end

	always @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			kick_prev_reg <= 1'b0;
			wd_state_reg <= WD_OFF;
			wd_cnt_reg <= 32'h00000000;
			watchdog_expired_n <= 1'b0;
		end
		else
		begin
			kick_prev_reg <= kick_s;
			wd_state_reg <= wd_state_next;
			wd_cnt_reg <= wd_cnt_next;
			watchdog_expired_n <= (wd_state_next == WD_COUNT);
		end
	end

	// flag mirrors the comparator; no hold is applied
	always @*
	begin
		pf_flag_next = 1'b1;
		if (!pf_s)
			pf_flag_next = 1'b0;
	end

	always @(posedge sys_clk)
	begin
		if (sys_rst)
			power_fail_flag_n <= 1'b1;
		else
			power_fail_flag_n <= pf_flag_next;
	end
endmodule // ssw_supervisor

// [ssw_supervisor_properties.sv]
// pin assertions for the supervisor
// bound into ssw_supervisor, one clock
module ssw_supervisor_properties #(
	parameter HOLD_CYC = 50,
	parameter WD_CYC = 200
) (
	input wire sys_clk,
	input wire sys_rst,
	input wire supply_low,
	input wire manual_reset_n,
	input wire manual_reset_n_oe_n,
	input wire watchdog_kick,
	input wire power_fail_sense,
	input wire reset_n,
	input wire watchdog_expired_n,
	input wire power_fail_flag_n
);
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);
	wire man_lo = !manual_reset_n && !manual_reset_n_oe_n;
	int ok_cnt = 0;
	int wd_cnt = 0;
	logic kick_reg = 1'b0;
	always @(posedge sys_clk)
	begin
		kick_reg <= watchdog_kick;
		ok_cnt <= sys_rst || supply_low || man_lo ? 0 : ok_cnt + 1;
		wd_cnt <= !reset_n || kick_reg != watchdog_kick ? 0 : wd_cnt + 1;
	end
	sequence man_held;
		man_lo[*8] ##1 man_lo[*8];
	endsequence
	pf_low_a: assert property ((!power_fail_sense)[*7] |-> !power_fail_flag_n)
		else $error("pf");
	uv_low_a: assert property (supply_low[*7] |-> !reset_n && !watchdog_expired_n)
		else $error("uv");
	man_rst_a: assert property (man_held |-> !reset_n)
		else $error("man");
	hold_min_a: assert property ($rose(reset_n) |-> ok_cnt >= HOLD_CYC - 1)
		else $error("short");
	hold_max_a: assert property (ok_cnt > HOLD_CYC + 8 |-> reset_n)
		else $error("long");
	wd_exp_a: assert property (wd_cnt > WD_CYC + 8 |-> !watchdog_expired_n)
		else $error("wd");
endmodule // ssw_supervisor_properties
bind ssw_supervisor ssw_supervisor_properties #(.HOLD_CYC(HOLD_CYC),
	.WD_CYC(WD_CYC)) chk (.*);

// [ssw_cpu_model.sv]
// processor model toggling the kick pin
// assumes run and gap come from the bench
module ssw_cpu_model (
	input wire sys_clk,
	input wire run,
	input wire [7:0] gap,
	output logic watchdog_kick = 1'b0
);
	logic [7:0] cnt_reg = 8'h00;
	always @(negedge sys_clk)
	begin
		cnt_reg <= run && cnt_reg < gap ? cnt_reg + 8'h01 : 8'h00;
		if (run && cnt_reg == gap)
			watchdog_kick <= !watchdog_kick;
	end
endmodule // ssw_cpu_model

// [ssw_supervisor_test.sv]
// supervisor bench, random sense and kick gap
// assumes the checker is bound by its own file
module ssw_supervisor_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 0, sys_rst = 1, low = 0, man_n = 1, oe_n = 0;
	logic pf = 1, run = 0, kick, rst_n, wd_n, pf_n;
	logic [7:0] gap = 8'h20;
	int seed = 32'h3f7d2cd4, miscompares = 0, n_tests = 0, cyc = 0;
	always #10 sys_clk = !sys_clk;
	ssw_supervisor #(.HOLD_CYC(50), .WD_CYC(200)) dut (.sys_clk(sys_clk),
		.sys_rst(sys_rst), .supply_low(low), .manual_reset_n(man_n),
		.manual_reset_n_oe_n(oe_n), .watchdog_kick(kick),
		.power_fail_sense(pf), .reset_n(rst_n),
		.watchdog_expired_n(wd_n), .power_fail_flag_n(pf_n));
	ssw_cpu_model cpu (.sys_clk(sys_clk), .run(run), .gap(gap),
		.watchdog_kick(kick));
	task w(int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task chk(string s, logic e, logic g);
		n_tests++;
		if (g !== e)
		begin
			miscompares++;
			$display("FAIL %s exp %b got %b", s, e, g);
		end
	endtask
	task finish_test;
		if (miscompares == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	always @(posedge sys_clk)
		if (++cyc == 3000)
		begin
			miscompares++;
			finish_test;
		end
	initial
	begin
		w(2);
		sys_rst = 0;
		w(40);
		chk("reset_n", 0, rst_n);
		repeat (12)
		begin
			pf = $random(seed);
			w(8);
			chk("power_fail_flag_n", pf, pf_n);
		end
		man_n = 0;
		w(3);
		man_n = 1;
		w(12);
		chk("reset_n", 1, rst_n);
		man_n = 0;
		w(20);
		man_n = 1;
		w(25);
		man_n = 0;
		w(20);
		man_n = 1;
		w(45);
		chk("reset_n", 0, rst_n);
		w(15);
		chk("reset_n", 1, rst_n);
		oe_n = 1;
		man_n = 0;
		w(30);
		chk("reset_n", 1, rst_n);
		low = 1;
		w(10);
		low = 0;
		w(7);
		chk("watchdog_expired_n", 1, wd_n);
		gap = 8'h14 + 8'($random(seed) & 31);
		run = 1;
		w(600);
		chk("watchdog_expired_n", 1, wd_n);
		run = 0;
		w(230);
		chk("watchdog_expired_n", 0, wd_n);
		chk("reset_n", 1, rst_n);
		run = 1;
		w(90);
		chk("watchdog_expired_n", 1, wd_n);
		finish_test;
	end
endmodule // ssw_supervisor_test
